/* File: rtl/cbs_pkg.sv */
/*
 * cbs_pkg: constants and state types of the can receive buffer block.
 * assumes a 32-bit classic wishbone slave port and one 250 MHz clock.
 */
package cbs_pkg;
  // buffer geometry
  localparam int NUM_MB  = 4;
  localparam int IDX_W   = 2;
  localparam int CODE_W  = 4;
  localparam int TS_W    = 16;
  localparam int LOCAL_TX_PRIORITY_W  = 3;
  localparam int ID_W    = 29;
  localparam int STD_W   = 11;
  localparam int EXT_W   = 18;
  localparam int DLC_W   = 4;
  localparam int DATA_W  = 64;

  // receive and transmit codes
  localparam logic [3:0] CODE_INACTIVE = 4'h0;
  localparam logic [3:0] CODE_EMPTY    = 4'h4;
  localparam logic [3:0] CODE_FULL     = 4'h2;
  localparam logic [3:0] CODE_OVERRUN  = 4'h6;
  localparam logic [3:0] CODE_TX_IDLE  = 4'h8;
  localparam logic [3:0] CODE_TX_SEND  = 4'hc;

  // byte addresses of global registers
  localparam logic [7:0] ADR_CONFIG   = 8'h00;
  localparam logic [7:0] ADR_TIMER    = 8'h04;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;
  // buffers: 0x80 + 0x10 * index, word select in bits 3:2
  localparam logic [1:0] WRD_CS  = 2'h0;
  localparam logic [1:0] WRD_ID  = 2'h1;
  localparam logic [1:0] WRD_DHI = 2'h2;
  localparam logic [1:0] WRD_DLO = 2'h3;

  // field positions
  localparam int CS_CODE_LSB = 24;
  localparam int CS_IDE_BIT  = 21;
  localparam int CS_DLC_LSB  = 16;
  localparam int ID_LOCAL_TX_PRIORITY_LSB = 29;
  localparam int CFG_LPE_BIT = 0;

  // transmit sequencer, gray coded
  typedef enum logic {
    TXS_IDLE = 1'b0,
    TXS_BUSY = 1'b1
  } cbs_tx_e;

  typedef struct packed {
    logic [NUM_MB-1:0][CODE_W-1:0] code;
    logic [NUM_MB-1:0]             ide;
    logic [NUM_MB-1:0][DLC_W-1:0]  dlc;
    logic [NUM_MB-1:0][TS_W-1:0]   ts;
    logic [NUM_MB-1:0][LOCAL_TX_PRIORITY_W-1:0] local_tx_priority;
    logic [NUM_MB-1:0][ID_W-1:0]   id;
    logic [NUM_MB-1:0][DATA_W-1:0] data;
    logic [NUM_MB-1:0]             seen;
    logic                          lock_v;
    logic [IDX_W-1:0]              lock_idx;
    logic                          lpe;
    logic [TS_W-1:0]               timer;
    logic [TS_W-1:0]               ts_hold;
    logic [NUM_MB-1:0]             irq_stat;
    logic [NUM_MB-1:0]             irq_mask;
    logic                          irq;
    logic                          ack;
    logic [31:0]                   rdat;
    cbs_tx_e                       txs;
    logic                          tx_v;
    logic [IDX_W-1:0]              tx_idx;
    logic [ID_W-1:0]               tx_id;
    logic                          tx_ide;
    logic [DLC_W-1:0]              tx_dlc;
    logic [DATA_W-1:0]             tx_data;
    logic                          rx_hit;
    logic [IDX_W-1:0]              rx_idx;
  } cbs_state_s;
endpackage

/* File: rtl/cbs_buffer.sv */
/*
 * cbs_buffer: message buffer store with receive code handling,
 * timestamps, local transmit priority and a wishbone register port.
 * assumes the protocol engine sits on the same clock and gives
 * one-cycle pulses; the bus master is a classic wishbone master.
 */
// Chosen here: the Wishbone interface to the registers and the register addresses.
// Functional notes
// - timer copy stored at identifier start
// - local priority used only when enabled
// - priority prepended for arbitration, never sent
// - standard frames use identifier bits 28:18
// - extended frames use all identifier bits
// - eight data bytes stored as received
// - inactive buffers never match nor receive
// - empty buffer becomes full after reception
// - read then unlocked full stays full
// - unread full buffer overwritten becomes overrun
// - read then unlocked overrun returns full
// - unread overrun buffer overwritten stays overrun
`timescale 1ns/1ns
module cbs_buffer (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic             wb_ack_out,
  output logic      [31:0] wb_dat_out,
  // interrupt
  output logic             irq_out,
  // protocol engine, receive side
  input  wire logic        id_start_in,
  input  wire logic        rx_valid_in,
  input  wire logic [28:0] rx_id_in,
  input  wire logic        rx_ide_in,
  input  wire logic [3:0]  rx_dlc_in,
  input  wire logic [63:0] rx_data_in,
  output logic             rx_stored_out,
  output logic      [1:0]  rx_index_out,
  // protocol engine, transmit side
  input  wire logic        tx_done_in,
  output logic             tx_valid_out,
  output logic      [1:0]  tx_index_out,
  output logic      [28:0] tx_id_out,
  output logic             tx_ide_out,
  output logic      [3:0]  tx_dlc_out,
  output logic      [63:0] tx_data_out
);

  cbs_pkg::cbs_state_s s_r;
  cbs_pkg::cbs_state_s s_nxt;

  // identifier as seen by matching and arbitration
  function automatic logic [28:0] id_key(input logic [28:0] id, input logic ide);
    if (ide) begin
      id_key = id;
    end else begin
      id_key = {id[28:18], 18'h00000};
    end
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    wmerge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        wmerge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // receive codes that take part in matching
  function automatic logic rx_active(input logic [3:0] c);
    rx_active = (c == cbs_pkg::CODE_EMPTY) || (c == cbs_pkg::CODE_FULL) ||
                (c == cbs_pkg::CODE_OVERRUN);
  endfunction

  logic        acc;
  logic        mb_sel;
  logic [1:0]  mb_i;
  logic [1:0]  mb_w;
  logic [31:0] rd;
  logic [31:0] cs_old;
  logic [31:0] w;
  logic        hit;
  logic [1:0]  hit_idx;
  logic        best_v;
  logic [1:0]  best_idx;
  logic [31:0] best_key;
  logic [31:0] key;

  // all next-state logic
  always_comb begin
    s_nxt = s_r;
    acc = wb_cyc_in & wb_stb_in & ~s_r.ack;
    mb_sel = wb_adr_in[7] & ~wb_adr_in[6];
    mb_i = wb_adr_in[5:4];
    mb_w = wb_adr_in[3:2];
    rd = 32'h00000000;
    w = 32'h00000000;
    cs_old = {4'h0, s_r.code[mb_i], 2'h0, s_r.ide[mb_i], 1'b0, s_r.dlc[mb_i], s_r.ts[mb_i]};
    hit = 1'b0;
    hit_idx = 2'h0;
    best_v = 1'b0;
    best_idx = 2'h0;
    best_key = 32'hffffffff;
    key = 32'h00000000;
    s_nxt.ack = acc;
    s_nxt.rx_hit = 1'b0;
    s_nxt.timer = s_r.timer + 16'h0001;
    // free-running timer sampled when the identifier starts
    if (id_start_in) begin
      s_nxt.ts_hold = s_r.timer;
    end
    // register access; hardware updates below win over it
    if (acc && mb_sel) begin
      case (mb_w)
        cbs_pkg::WRD_CS: begin
          rd = cs_old;
          if (wb_we_in) begin
            w = wmerge(cs_old, wb_dat_in, wb_sel_in);
            s_nxt.code[mb_i] = w[cbs_pkg::CS_CODE_LSB +: 4];
            s_nxt.ide[mb_i] = w[cbs_pkg::CS_IDE_BIT];
            s_nxt.dlc[mb_i] = w[cbs_pkg::CS_DLC_LSB +: 4];
          end else begin
            s_nxt.seen[mb_i] = 1'b1;
            s_nxt.lock_v = 1'b1;
            s_nxt.lock_idx = mb_i;
          end
        end
        cbs_pkg::WRD_ID: begin
          rd = {s_r.local_tx_priority[mb_i], s_r.id[mb_i]};
          if (wb_we_in) begin
            w = wmerge(rd, wb_dat_in, wb_sel_in);
            s_nxt.local_tx_priority[mb_i] = w[cbs_pkg::ID_LOCAL_TX_PRIORITY_LSB +: 3];
            s_nxt.id[mb_i] = w[28:0];
          end
        end
        cbs_pkg::WRD_DHI: begin
          rd = s_r.data[mb_i][63:32];
          if (wb_we_in) begin
            s_nxt.data[mb_i][63:32] = wmerge(rd, wb_dat_in, wb_sel_in);
          end
        end
        default: begin
          rd = s_r.data[mb_i][31:0];
          if (wb_we_in) begin
            s_nxt.data[mb_i][31:0] = wmerge(rd, wb_dat_in, wb_sel_in);
          end
        end
      endcase
    end else if (acc) begin
      case (wb_adr_in)
        cbs_pkg::ADR_CONFIG: begin
          rd[cbs_pkg::CFG_LPE_BIT] = s_r.lpe;
          if (wb_we_in && wb_sel_in[0]) begin
            s_nxt.lpe = wb_dat_in[cbs_pkg::CFG_LPE_BIT];
          end
        end
        cbs_pkg::ADR_TIMER: begin
          rd[15:0] = s_r.timer;
          // timer read releases the lock
          if (!wb_we_in) begin
            s_nxt.lock_v = 1'b0;
          end
        end
        cbs_pkg::ADR_IRQ_STAT: begin
          rd[3:0] = s_r.irq_stat;
          if (!wb_we_in) begin
            s_nxt.irq_stat = 4'h0;
          end
        end
        cbs_pkg::ADR_IRQ_MASK: begin
          rd[3:0] = s_r.irq_mask;
          if (wb_we_in && wb_sel_in[0]) begin
            s_nxt.irq_mask = wb_dat_in[3:0];
          end
        end
        default: begin
          rd = 32'h00000000; // unmapped reads zero, writes dropped
        end
      endcase
    end
    s_nxt.rdat = rd;
    // matching: lowest index wins; a locked buffer is skipped
    for (int i = cbs_pkg::NUM_MB - 1; i >= 0; i--) begin
      if (rx_active(s_r.code[i]) &&
          !(s_r.lock_v && s_r.lock_idx == 2'(i)) &&
          s_r.ide[i] == rx_ide_in &&
          id_key(s_r.id[i], s_r.ide[i]) == id_key(rx_id_in, rx_ide_in)) begin
        hit = 1'b1;
        hit_idx = 2'(i);
      end
    end
    // store a received frame and move its code
    if (rx_valid_in && hit) begin
      if (s_r.code[hit_idx] == cbs_pkg::CODE_EMPTY) begin
        s_nxt.code[hit_idx] = cbs_pkg::CODE_FULL;
      end else if (s_r.seen[hit_idx]) begin
        s_nxt.code[hit_idx] = cbs_pkg::CODE_FULL;
      end else begin
        s_nxt.code[hit_idx] = cbs_pkg::CODE_OVERRUN;
      end
      s_nxt.id[hit_idx] = rx_id_in;
      s_nxt.ide[hit_idx] = rx_ide_in;
      s_nxt.dlc[hit_idx] = rx_dlc_in;
      s_nxt.data[hit_idx] = rx_data_in;
      s_nxt.ts[hit_idx] = s_r.ts_hold;
      s_nxt.seen[hit_idx] = 1'b0;
      s_nxt.irq_stat[hit_idx] = 1'b1;
      s_nxt.rx_hit = 1'b1;
      s_nxt.rx_idx = hit_idx;
    end
    // arbitration key: priority on top only when enabled
    for (int i = cbs_pkg::NUM_MB - 1; i >= 0; i--) begin
      key = {(s_r.lpe ? s_r.local_tx_priority[i] : 3'h0), id_key(s_r.id[i], s_r.ide[i])};
      if (s_r.code[i] == cbs_pkg::CODE_TX_SEND && key <= best_key) begin
        best_v = 1'b1;
        best_idx = 2'(i);
        best_key = key;
      end
    end
    // transmit sequencer; priority bits never leave the block
    case (s_r.txs)
      cbs_pkg::TXS_IDLE: begin
        if (best_v) begin
          s_nxt.txs = cbs_pkg::TXS_BUSY;
          s_nxt.tx_v = 1'b1;
          s_nxt.tx_idx = best_idx;
          s_nxt.tx_id = s_r.id[best_idx];
          s_nxt.tx_ide = s_r.ide[best_idx];
          s_nxt.tx_dlc = s_r.dlc[best_idx];
          s_nxt.tx_data = s_r.data[best_idx];
        end
      end
      cbs_pkg::TXS_BUSY: begin
        if (tx_done_in) begin
          s_nxt.txs = cbs_pkg::TXS_IDLE;
          s_nxt.tx_v = 1'b0;
          s_nxt.code[s_r.tx_idx] = cbs_pkg::CODE_TX_IDLE;
          s_nxt.ts[s_r.tx_idx] = s_r.ts_hold;
          s_nxt.irq_stat[s_r.tx_idx] = 1'b1;
        end
      end
      default: begin
        s_nxt.txs = cbs_pkg::TXS_IDLE;
        s_nxt.tx_v = 1'b0;
      end
    endcase
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  // single state register; buffers reset inactive
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign wb_ack_out    = s_r.ack;
  assign wb_dat_out    = s_r.rdat;
  assign irq_out       = s_r.irq;
  assign rx_stored_out = s_r.rx_hit;
  assign rx_index_out  = s_r.rx_idx;
  assign tx_valid_out  = s_r.tx_v;
  assign tx_index_out  = s_r.tx_idx;
  assign tx_id_out     = s_r.tx_id;
  assign tx_ide_out    = s_r.tx_ide;
  assign tx_dlc_out    = s_r.tx_dlc;
  assign tx_data_out   = s_r.tx_data;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  rx_timestamp_a: assert property (
    s_r.rx_hit |-> s_r.ts[s_r.rx_idx] == $past(s_r.ts_hold))
    else $error("stored timestamp differs from captured timer");
  inactive_skip_a: assert property (
    rx_valid_in && hit |-> s_r.code[hit_idx] != cbs_pkg::CODE_INACTIVE)
    else $error("inactive buffer matched");
  empty_to_full_a: assert property (
    rx_valid_in && hit && s_r.code[hit_idx] == cbs_pkg::CODE_EMPTY
    |=> s_r.code[s_r.rx_idx] == cbs_pkg::CODE_FULL)
    else $error("empty buffer did not become full");
  read_full_a: assert property (
    rx_valid_in && hit && s_r.seen[hit_idx] |=> s_r.code[s_r.rx_idx] == cbs_pkg::CODE_FULL)
    else $error("read buffer did not end full");
  overrun_set_a: assert property (
    rx_valid_in && hit && !s_r.seen[hit_idx] && s_r.code[hit_idx] != cbs_pkg::CODE_EMPTY
    |=> s_r.code[s_r.rx_idx] == cbs_pkg::CODE_OVERRUN)
    else $error("unread overwrite did not give overrun");
  std_match_a: assert property (
    rx_valid_in && hit && !rx_ide_in |-> s_r.id[hit_idx][28:18] == rx_id_in[28:18])
    else $error("standard match on wrong bits");
  ext_match_a: assert property (
    rx_valid_in && hit && rx_ide_in |-> s_r.id[hit_idx] == rx_id_in)
    else $error("extended match on partial identifier");
  rx_data_a: assert property (
    s_r.rx_hit |-> s_r.data[s_r.rx_idx] == $past(rx_data_in))
    else $error("received data not stored as is");
  lock_hold_a: assert property (
    rx_valid_in && hit |-> !(s_r.lock_v && s_r.lock_idx == hit_idx))
    else $error("locked buffer updated");
  tx_pick_a: assert property (
    $rose(s_r.tx_v) |-> s_r.tx_id == s_r.id[s_r.tx_idx] &&
    s_r.code[s_r.tx_idx] == cbs_pkg::CODE_TX_SEND)
    else $error("transmit winner not a send buffer");
  // transmit completion and lock bookkeeping
  tx_timestamp_a: assert property (
    s_r.txs == cbs_pkg::TXS_BUSY && tx_done_in
    |=> s_r.ts[s_r.tx_idx] == $past(s_r.ts_hold) &&
    s_r.code[s_r.tx_idx] == cbs_pkg::CODE_TX_IDLE)
    else $error("transmit end did not stamp and idle the buffer");
  cs_read_lock_a: assert property (
    acc && mb_sel && mb_w == cbs_pkg::WRD_CS && !wb_we_in
    |=> s_r.lock_v && s_r.lock_idx == $past(mb_i))
    else $error("control word read did not lock its buffer");
  // ack is a single pulse; irq follows the masked status
  ack_pulse_a: assert property (
    s_r.ack |=> !s_r.ack)
    else $error("acknowledge held longer than one cycle");
  irq_level_a: assert property (
    s_r.irq == |(s_r.irq_stat & s_r.irq_mask))
    else $error("interrupt level differs from masked status");

  // main scenarios
  full_store_c: cover property (s_r.rx_hit && s_r.code[s_r.rx_idx] == cbs_pkg::CODE_FULL);
  overrun_c: cover property (s_r.rx_hit && s_r.code[s_r.rx_idx] == cbs_pkg::CODE_OVERRUN);
  tx_done_c: cover property (s_r.tx_v && tx_done_in);
  lpe_arb_c: cover property (s_r.lpe && $rose(s_r.tx_v));

endmodule

/* File: dv/cbs_can_node.sv */
/*
 * cbs_can_node: model of the bus side: sends a frame on request and
 * ends each transmit after a chosen wait.
 * assumes the bench pulses send_in one cycle and holds the fields until
 * rx_valid_out falls, one cycle after busy_out falls.
 */
`timescale 1ns/1ns
module cbs_can_node (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // frame request from the bench
  input  wire logic        send_in,
  input  wire logic [28:0] id_in,
  input  wire logic        ide_in,
  input  wire logic [63:0] data_in,
  input  wire logic [3:0]  tx_wait_in,
  // toward the buffer block
  output logic             id_start_out,
  output logic             rx_valid_out,
  output logic      [28:0] rx_id_out,
  output logic             rx_ide_out,
  output logic      [63:0] rx_data_out,
  input  wire logic        tx_valid_in,
  output logic             tx_done_out,
  output logic             busy_out
);
  logic [3:0] rx_cnt_r;
  logic [3:0] tx_cnt_r;

  // fields outside the valid cycle show the inverse, never stale values
  assign rx_id_out   = rx_valid_out ? id_in : ~id_in;
  assign rx_ide_out  = rx_valid_out ? ide_in : ~ide_in;
  assign rx_data_out = rx_valid_out ? data_in : ~data_in;
  assign busy_out    = rx_cnt_r != 4'h0;

  // identifier start first, whole frame a few cycles later
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rx_cnt_r     <= 4'h0;
      tx_cnt_r     <= 4'h0;
      id_start_out <= 1'b0;
      rx_valid_out <= 1'b0;
      tx_done_out  <= 1'b0;
    end else begin
      id_start_out <= send_in && rx_cnt_r == 4'h0;
      rx_valid_out <= rx_cnt_r == 4'h1;
      if (send_in && rx_cnt_r == 4'h0) begin
        rx_cnt_r <= 4'h4;
      end else if (rx_cnt_r != 4'h0) begin
        rx_cnt_r <= rx_cnt_r - 4'h1;
      end
      // a slow wait leaves room for the host to queue more buffers
      tx_done_out <= tx_valid_in && !tx_done_out && tx_cnt_r == tx_wait_in;
      tx_cnt_r <= (tx_valid_in && !tx_done_out && tx_cnt_r != tx_wait_in) ?
                  tx_cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule

/* File: dv/cbs_buffer_tb.sv */
/*
 * cbs_buffer_tb: wishbone tests of receive codes, matching, data,
 * timestamps, interrupt and transmit arbitration.
 * assumes the package and buffer block of rtl/ and the node model.
 */
`timescale 1ns/1ns
module cbs_buffer_tb;
  localparam logic [28:0] ID_A = 29'h0abcdef1;
  localparam logic [28:0] ID_S = {11'h5a5, 18'h00000};
  localparam logic [28:0] ID_E = 29'h01234567;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        wb_req = 1'b0;
  logic        we = 1'b0;
  logic        send = 1'b0;
  logic        f_ide = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'hf;
  logic [28:0] f_id = 29'h0;
  logic [31:0] rd, rdat;
  logic [28:0] rx_id, tid;
  logic [63:0] rx_data, tdata;
  logic [3:0]  tdlc;
  logic [1:0]  ridx, tidx;
  logic        ack, irq, id_st, rxv, rx_ide, stored, txd, txv, tide, busy;
  logic [15:0] t_id, t_prev, ts_prev;
  int          n_mismatch = 0, checked = 0, n_store = 0, cyc_cnt = 0, k;
  int          nf [5] = '{1, 1, 2, 1, 3};
  logic [3:0]  ec [5] = '{cbs_pkg::CODE_FULL, cbs_pkg::CODE_FULL, cbs_pkg::CODE_OVERRUN,
                          cbs_pkg::CODE_FULL, cbs_pkg::CODE_OVERRUN};

  always #2 clk_in = ~clk_in;

  cbs_buffer u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_req),
    .wb_stb_in(wb_req), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_ack_out(ack), .wb_dat_out(rdat), .irq_out(irq), .id_start_in(id_st),
    .rx_valid_in(rxv), .rx_id_in(rx_id), .rx_ide_in(rx_ide), .rx_dlc_in(4'h8),
    .rx_data_in(rx_data), .rx_stored_out(stored), .rx_index_out(ridx), .tx_done_in(txd),
    .tx_valid_out(txv), .tx_index_out(tidx), .tx_id_out(tid), .tx_ide_out(tide),
    .tx_dlc_out(tdlc), .tx_data_out(tdata));

  cbs_can_node u_node (.clk_in(clk_in), .rst_b_in(rst_b_in), .send_in(send), .id_in(f_id),
    .ide_in(f_ide), .data_in({f_id[7:0], 56'h0123456789abcd}), .tx_wait_in(4'hf),
    .id_start_out(id_st), .rx_valid_out(rxv), .rx_id_out(rx_id), .rx_ide_out(rx_ide),
    .rx_data_out(rx_data), .tx_valid_in(txv), .tx_done_out(txd), .busy_out(busy));

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle, held until ack is sampled; read data lands in rd
  task automatic bus(input int w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_req <= 1'b1;
    we <= (w != 0);
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    wb_req <= 1'b0;
    if (n >= 20) check("ack", 32'h0, 32'h1);
  endtask

  task automatic frame(input logic [28:0] id, input logic ide);
    f_id <= id;
    f_ide <= ide;
    send <= 1'b1;
    @(posedge clk_in);
    send <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask

  function automatic logic [7:0] mb(input logic [1:0] n, input logic [1:0] w);
    return {2'b10, n, w, 2'b00};
  endfunction

  function automatic logic [31:0] cs(input logic [3:0] c, input logic ide);
    return {4'h0, c, 2'b00, ide, 1'b0, 4'h8, 16'h0000};
  endfunction

  // stamp capture, store count and hang guard
  always @(posedge clk_in) begin
    cyc_cnt++;
    if (id_st === 1'b1) t_id = cyc_cnt[15:0];
    if (stored === 1'b1) n_store++;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    bus(0, cbs_pkg::ADR_IRQ_MASK, 0);
    check("mask reset", rd, 32'h0);
    bus(0, 8'h40, 0);
    check("hole", rd, 32'h0);
    $display("test reset done");
    // inactive buffer 0 shares the identifier of empty buffer 1
    bus(1, cbs_pkg::ADR_IRQ_MASK, 32'h2);
    bus(1, mb(0, cbs_pkg::WRD_ID), {3'h0, ID_A});
    bus(1, mb(1, cbs_pkg::WRD_ID), {3'h0, ID_A});
    bus(1, mb(1, cbs_pkg::WRD_CS), cs(cbs_pkg::CODE_EMPTY, 1'b1));
    for (int i = 0; i < 5; i++) begin
      repeat (nf[i]) frame(ID_A, 1'b1);
      check("rx index", {30'h0, ridx}, 32'h1);
      bus(0, mb(1, cbs_pkg::WRD_CS), 0);
      check("rx code", {28'h0, rd[27:24]}, {28'h0, ec[i]});
      if (i > 0) check("stamp", {16'h0, rd[15:0] - ts_prev}, {16'h0, t_id - t_prev});
      ts_prev = rd[15:0];
      t_prev = t_id;
      bus(0, cbs_pkg::ADR_TIMER, 0);
    end
    bus(0, mb(1, cbs_pkg::WRD_DHI), 0);
    check("data hi", rd, {ID_A[7:0], 24'h012345});
    bus(0, mb(1, cbs_pkg::WRD_DLO), 0);
    check("data lo", rd, 32'h6789abcd);
    check("irq on", {31'h0, irq}, 32'h1);
    bus(0, cbs_pkg::ADR_IRQ_STAT, 0);
    check("irq stat", rd, 32'h2);
    repeat (2) @(posedge clk_in);
    check("irq off", {31'h0, irq}, 32'h0);
    $display("test codes done");
    // a control word read holds off receives into buffer 1 until unlocked
    bus(0, mb(1, cbs_pkg::WRD_CS), 0);
    k = n_store;
    frame(ID_A, 1'b1);
    check("locked", n_store, k);
    bus(1, cbs_pkg::ADR_IRQ_MASK, 0);
    bus(0, cbs_pkg::ADR_TIMER, 0);
    frame(ID_A, 1'b1);
    check("unlocked", n_store, k + 1);
    check("irq masked", {31'h0, irq}, 32'h0);
    $display("test lock done");
    // standard key ignores the low 18 bits, extended uses all
    bus(1, mb(2, cbs_pkg::WRD_ID), {3'h0, ID_S});
    bus(1, mb(2, cbs_pkg::WRD_CS), cs(cbs_pkg::CODE_EMPTY, 1'b0));
    bus(1, mb(3, cbs_pkg::WRD_ID), {3'h0, ID_E});
    bus(1, mb(3, cbs_pkg::WRD_CS), cs(cbs_pkg::CODE_EMPTY, 1'b1));
    frame(ID_S ^ 29'h0003ffff, 1'b0);
    check("std index", {30'h0, ridx}, 32'h2);
    bus(0, mb(2, cbs_pkg::WRD_ID), 0);
    check("std id", {3'h0, rd[28:0]}, {3'h0, ID_S ^ 29'h0003ffff});
    k = n_store;
    frame(ID_E ^ 29'h1, 1'b1);
    check("ext miss", n_store, k);
    frame(ID_E, 1'b1);
    check("ext index", {30'h0, ridx}, 32'h3);
    $display("test match done");
    // host fills send data; a half-word write merges into the low word
    bus(1, mb(2, cbs_pkg::WRD_DHI), 32'h0f1e2d3c);
    bus(1, mb(2, cbs_pkg::WRD_DLO), 32'h4b5a6978);
    bus(1, mb(3, cbs_pkg::WRD_DHI), 32'h8796a5b4);
    bus(1, mb(3, cbs_pkg::WRD_DLO), 32'hc3d2e1f0);
    sel <= 4'h3;
    bus(1, mb(3, cbs_pkg::WRD_DLO), 32'h00005555);
    sel <= 4'hf;
    // buffer 1 keeps the engine busy while 2 and 3 queue up
    for (int r = 0; r < 2; r++) begin
      bus(1, cbs_pkg::ADR_CONFIG, r);
      bus(1, mb(2, cbs_pkg::WRD_ID), {3'h0, 29'h1fff0000});
      bus(1, mb(3, cbs_pkg::WRD_ID), {3'h7, 29'h00001000});
      bus(1, mb(1, cbs_pkg::WRD_CS), cs(cbs_pkg::CODE_TX_SEND, 1'b1));
      bus(1, mb(2, cbs_pkg::WRD_CS), cs(cbs_pkg::CODE_TX_SEND, 1'b1));
      bus(1, mb(3, cbs_pkg::WRD_CS), cs(cbs_pkg::CODE_TX_SEND, 1'b1));
      k = 0;
      while (!(txv === 1'b1 && tidx !== 2'h1) && k < 100) begin
        @(posedge clk_in);
        k++;
      end
      check("tx pick", {30'h0, tidx}, r ? 32'h2 : 32'h3);
      check("tx id", {3'h0, tid}, r ? 32'h1fff0000 : 32'h00001000);
      check("tx ide", {31'h0, tide}, 32'h1);
      check("tx dlc", {28'h0, tdlc}, 32'h8);
      check("tx data hi", tdata[63:32], r ? 32'h0f1e2d3c : 32'h8796a5b4);
      check("tx data lo", tdata[31:0], r ? 32'h4b5a6978 : 32'hc3d25555);
      repeat (90) @(posedge clk_in);
      check("tx off", {31'h0, txv}, 32'h0);
      bus(0, mb(r ? 2'h2 : 2'h3, cbs_pkg::WRD_CS), 0);
      check("tx code", {28'h0, rd[27:24]}, {28'h0, cbs_pkg::CODE_TX_IDLE});
      check("tx stamp", {16'h0, rd[15:0]}, {16'h0, t_id + ts_prev - t_prev});
    end
    $display("test transmit done");
    tally_and_finish();
  end
endmodule
